// [tb/mrs_pin_model.sv]
// Model: board reset source on the open-drain pin
`timescale 1ns/1ps
`default_nettype none
module mrs_pin_model (
  input wire logic pull_low,
  input wire logic dev_oe,
  input wire logic dev_o,
  output logic pin
);
  // Pull-up wins unless a party sinks the line
  assign pin = !((dev_oe && !dev_o) || pull_low);
endmodule
`default_nettype wire

// [tb/mrs_reset_seq_asserts.sv]
// Checker: reset sequencer port assertions
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic stop_recovery,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_pullup_en,
  input wire logic core_rst_n,
  input wire logic periph_rst_n,
  input wire logic wdog_osc_reg_load,
  input wire logic [7:0] wdog_ctl_rst_val,
  input wire logic [7:0] oscillator_control_reg_rst_val,
  input wire logic ctrl_reg_load,
  input wire logic [1:0] clk_sel,
  input wire logic clk_sel_load,
  input wire logic xtal_osc_run,
  input wire logic wdog_osc_run,
  input wire logic [mrs_pkg::GPIO_W-1:0] gpio_dir_in,
  input wire logic [mrs_pkg::GPIO_W-1:0] gpio_pullup_en,
  input wire logic gpio_cfg_load,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_addr,
  input wire logic pc_load
);
  import mrs_pkg::*;
  logic [15:0] oe_run_q, oe_run_d;
  // Length of the current stretch of own pin drive
  always_comb begin
    oe_run_d = oe_run_q;
    if (!reset_pin_oe) begin
      oe_run_d = 16'h0000;
    end else if (oe_run_q != 16'hffff) begin
      oe_run_d = oe_run_q + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_run_q <= 16'h0000;
    end else begin
      oe_run_q <= oe_run_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Assertions
  pin_drive_a: assert property (reset_pin_oe |-> !reset_pin_o && !core_rst_n)
    else $error("pin driven outside reset");
  pullup_on_a: assert property (reset_pin_pullup_en)
    else $error("pin pull-up off");
  start_wait_a: assert property ($fell(core_rst_n) |-> reset_pin_oe [*8])
    else $error("startup wait cut short");
  hold_span_a: assert property ($fell(reset_pin_oe) |->
    oe_run_q >= 16'(OSC_START_CYC + HOLD_SHORT_CYC))
    else $error("startup plus hold too short");
  pin_reset_a: assert property (!reset_pin_i [*8] |-> !core_rst_n)
    else $error("run while pin held low");
  gpio_safe_a: assert property (gpio_cfg_load |->
    &gpio_dir_in && gpio_pullup_en == '0)
    else $error("gpio not safe in reset");
  osc_run_a: assert property (xtal_osc_run && wdog_osc_run)
    else $error("oscillator stopped");
  periph_core_a: assert property (periph_rst_n == core_rst_n)
    else $error("peripheral reset split from core");
  ctl_value_a: assert property (wdog_osc_reg_load |->
    wdog_ctl_rst_val == WDOG_CTL_RST && oscillator_control_reg_rst_val == OSC_CONTROL_REG_RST)
    else $error("control reset value wrong");
  sys_load_a: assert property (ctrl_reg_load |->
    wdog_osc_reg_load && clk_sel_load && gpio_cfg_load && !core_rst_n)
    else $error("system reload incomplete");
  run_quiet_a: assert property (core_rst_n |-> !ctrl_reg_load && !wdog_osc_reg_load)
    else $error("reload while running");
  clk_rc_a: assert property (clk_sel_load |-> clk_sel == CLKSEL_RC)
    else $error("clock not rc after reset");
  vec_order_a: assert property (vec_fetch && vec_addr == VEC_ADDR_HI |=>
    vec_fetch && vec_addr == VEC_ADDR_LO)
    else $error("vector order wrong");
  pc_load_a: assert property (pc_load |->
    core_rst_n && $past(vec_fetch) && $past(vec_addr) == VEC_ADDR_LO)
    else $error("pc load without fetch");
  stop_keep_a: assert property (stop_recovery && core_rst_n && reset_pin_i && supply_ok |=>
    !core_rst_n && !ctrl_reg_load)
    else $error("stop recovery reloaded regs");
endmodule
bind mrs_reset_seq mrs_reset_seq_asserts mrs_reset_seq_asserts_inst (.*);
`default_nettype wire

// [tb/mrs_reset_seq_tb.sv]
// Testbench: reset sequencer scenarios
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq_tb;
  import mrs_pkg::*;
  localparam int XH = 90;
  logic clk, rst_n, supply_ok, stop_recovery, xtal_opt_en, pull_low, pin, oe, po;
  logic core_rst_n, ctrl_reg_load, wd_load, pc_load;
  logic [15:0] vec_addr, pc_val;
  logic [7:0] vec_data;
  int error_cnt, num_checks, n;
  bit timed_out;
  // Memory answers in the same cycle
  assign vec_data = (vec_addr == 16'h0002) ? 8'ha5 : 8'h3c;
  mrs_pin_model mrs_pin_model_inst (.pull_low(pull_low), .dev_oe(oe), .dev_o(po), .pin(pin));
  mrs_reset_seq #(.HOLD_XTAL(XH)) mrs_reset_seq_inst (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .stop_recovery(stop_recovery),
    .xtal_opt_en(xtal_opt_en), .reset_pin_i(pin), .reset_pin_o(po), .reset_pin_oe(oe),
    .reset_pin_pullup_en(), .core_rst_n(core_rst_n), .periph_rst_n(),
    .ctrl_reg_load(ctrl_reg_load), .wdog_osc_reg_load(wd_load), .wdog_ctl_rst_val(),
    .oscillator_control_reg_rst_val(), .clk_sel(), .clk_sel_load(), .xtal_osc_run(),
    .wdog_osc_run(),
    .gpio_dir_in(), .gpio_pullup_en(), .gpio_cfg_load(), .vec_fetch(),
    .vec_addr(vec_addr), .vec_data(vec_data), .pc_load_val(pc_val), .pc_load(pc_load));
  // ====================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles to first run cycle; slack covers pin filter and vector fetch
  task automatic run_seq(input int lo);
    n = 0;
    while (!timed_out && pc_load !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    // A hang counts once; later waits are skipped so the report comes soon
    if (n >= 20000) begin
      timed_out = 1'b1;
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, lo);
    end else if (!timed_out) begin
      chk(16'(n >= lo && n <= lo + 14), 16'h0001);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic s_power();
    repeat (20) @(negedge clk);
    chk(16'(core_rst_n), 16'h0000);
    supply_ok = 1'b1;
    run_seq(OSC_START_CYC + HOLD_SHORT_CYC);
    chk(pc_val, 16'ha53c);
  endtask
  task automatic s_xtal();
    xtal_opt_en = 1'b1;
    pull_low = 1'b1;
    repeat (6) @(negedge clk);
    chk(16'(ctrl_reg_load), 16'h0001);
    pull_low = 1'b0;
    run_seq(OSC_START_CYC + XH);
    xtal_opt_en = 1'b0;
  endtask
  task automatic s_stretch();
    pull_low = 1'b1;
    repeat (400) @(negedge clk);
    chk(16'(core_rst_n), 16'h0000);
    pull_low = 1'b0;
    run_seq(2);
  endtask
  task automatic s_stop();
    stop_recovery = 1'b1;
    @(negedge clk);
    stop_recovery = 1'b0;
    repeat (3) @(negedge clk);
    chk({ctrl_reg_load, wd_load, core_rst_n}, 16'h0002);
    run_seq(OSC_START_CYC + HOLD_SHORT_CYC);
  endtask
  task automatic s_dip();
    supply_ok = 1'b0;
    repeat (30) @(negedge clk);
    chk({core_rst_n, ctrl_reg_load, wd_load}, 16'h0003);
    supply_ok = 1'b1;
    run_seq(OSC_START_CYC + HOLD_SHORT_CYC);
    chk(pc_val, 16'ha53c);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {supply_ok, stop_recovery, xtal_opt_en, pull_low} = 4'h0;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    s_power();
    s_xtal();
    s_stretch();
    s_stop();
    s_dip();
    summarize();
  end
endmodule
`default_nettype wire

// [verilog/mrs_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mrs_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;
  always_comb begin
    s1_d = pin_i;
    s2_d = s1_q;
    s3_d = s2_q;
    // Stages two and three must agree before the level moves
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end
  assign level_o = lvl_q;
endmodule
`default_nettype wire

// [verilog/mrs_pkg.sv]
// Package: constants for the reset sequencer
package mrs_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  // Oscillator startup time, nanoseconds
  localparam int unsigned OSC_START_NS = 4_000;
  // Least time rounds up to whole cycles
  localparam int unsigned OSC_START_CYC = (OSC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned HOLD_SHORT_CYC = 66;
  localparam int unsigned HOLD_XTAL_CYC = 5000;
  localparam int unsigned CNT_W = 13;
  localparam logic [15:0] VEC_ADDR_HI = 16'h0002;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0003;
  localparam logic [7:0] WDOG_CTL_RST = 8'h00;
  localparam logic [7:0] OSC_CONTROL_REG_RST = 8'h00;
  localparam logic [1:0] CLKSEL_RC = 2'h0;
  localparam int unsigned GPIO_W = 24;
endpackage

// [verilog/mrs_reset_seq.sv]
// Reset sequencer: startup wait, hold count, pin stretch, vector fetch
// Function
// - Wait oscillator startup before counting reset cycles
// - Hold core reset for 66 oscillator cycles
// - Crystal option lengthens hold to 5000 cycles
// - Power resets time from supply good
// - Stay in reset while pin asserted
// - External low on pin causes reset
// - Drive reset pin low during power wait, startup wait and hold
// - GPIO become inputs, pull-ups off
// - Core idle, crystal and watchdog oscillators run
// - Load control registers with reset values
// - Fetch vector from 0002H/0003H into PC
// - System reset selects RC oscillator clock
// - Stop recovery resets core and peripherals, reloads only watchdog, oscillator
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq #(
  parameter int unsigned HOLD_SHORT = mrs_pkg::HOLD_SHORT_CYC,
  parameter int unsigned HOLD_XTAL = mrs_pkg::HOLD_XTAL_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic stop_recovery,
  input wire logic xtal_opt_en,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic reset_pin_pullup_en,
  output logic core_rst_n,
  output logic periph_rst_n,
  output logic ctrl_reg_load,
  output logic wdog_osc_reg_load,
  output logic [7:0] wdog_ctl_rst_val,
  output logic [7:0] oscillator_control_reg_rst_val,
  output logic [1:0] clk_sel,
  output logic clk_sel_load,
  output logic xtal_osc_run,
  output logic wdog_osc_run,
  output logic [mrs_pkg::GPIO_W-1:0] gpio_dir_in,
  output logic [mrs_pkg::GPIO_W-1:0] gpio_pullup_en,
  output logic gpio_cfg_load,
  output logic vec_fetch,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic [15:0] pc_load_val,
  output logic pc_load
);
  import mrs_pkg::*;

  // Counter must reach the longer hold and the startup wait
  if (HOLD_SHORT < 1 || HOLD_XTAL < HOLD_SHORT || HOLD_XTAL >= (1 << CNT_W) ||
      OSC_START_CYC < 1 || OSC_START_CYC > (1 << CNT_W)) begin : g_bad_hold
    $error("mrs_reset_seq: hold counts out of range");
  end

  // ==========================================
  // Pin input
  logic pin_level;
  mrs_pin_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(reset_pin_i),
    .level_o(pin_level)
  );

  // ==========================================
  // Sequencer
  typedef enum logic [2:0] {
    MRS_POWER, MRS_START, MRS_HOLD, MRS_PIN, MRS_VEC_HI, MRS_VEC_LO, MRS_RUN
  } mrs_state_e;

  mrs_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic sys_q, sys_d;
  logic [7:0] vhi_q, vhi_d;
  logic [15:0] pc_q, pc_d;
  logic pcl_q, pcl_d;

  function automatic logic [CNT_W-1:0] hold_last(input logic xtal);
    hold_last = xtal ? CNT_W'(HOLD_XTAL - 1) : CNT_W'(HOLD_SHORT - 1);
  endfunction

  logic in_reset;
  assign in_reset = (st_q != MRS_RUN);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sys_d = sys_q;
    vhi_d = vhi_q;
    pc_d = pc_q;
    pcl_d = 1'b0;
    case (st_q)
      MRS_POWER: begin
        cnt_d = '0;
        if (supply_ok) begin
          st_d = MRS_START;
        end
      end
      MRS_START: begin
        if (cnt_q == CNT_W'(OSC_START_CYC - 1)) begin
          cnt_d = '0;
          st_d = MRS_HOLD;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      MRS_HOLD: begin
        // Option may change mid-hold; compare by magnitude so it never wraps
        if (cnt_q >= hold_last(xtal_opt_en)) begin
          st_d = MRS_PIN;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      MRS_PIN: begin
        // Our own drive is released here; a low pin means the external side holds it
        if (pin_level) begin
          st_d = MRS_VEC_HI;
        end
      end
      MRS_VEC_HI: begin
        vhi_d = vec_data;
        st_d = MRS_VEC_LO;
      end
      MRS_VEC_LO: begin
        pc_d = {vhi_q, vec_data};
        pcl_d = 1'b1;
        st_d = MRS_RUN;
      end
      MRS_RUN: begin
        sys_d = 1'b0;
        // Pin wins over stop recovery: a system reset reloads more
        if (!pin_level) begin
          sys_d = 1'b1;
          cnt_d = '0;
          st_d = MRS_START;
        end else if (stop_recovery) begin
          sys_d = 1'b0;
          cnt_d = '0;
          st_d = MRS_START;
        end
      end
      default: begin
        st_d = MRS_POWER;
      end
    endcase
    // Supply dip restarts everything, timed from its return
    if (!supply_ok) begin
      st_d = MRS_POWER;
      sys_d = 1'b1;
      cnt_d = '0;
    end
  end

  // Synchronous reset; rst_n sits in the same domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= MRS_POWER;
      cnt_q <= '0;
      sys_q <= 1'b1;
      vhi_q <= 8'h00;
      pc_q <= 16'h0000;
      pcl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sys_q <= sys_d;
      vhi_q <= vhi_d;
      pc_q <= pc_d;
      pcl_q <= pcl_d;
    end
  end

  // ==========================================
  // Outputs
  // Pin is released in the pin wait, vector fetch and run states, so the
  // synchronised level reflects the external party while we wait on it
  logic sys_load;
  assign sys_load = in_reset && sys_q;
  always_comb begin
    reset_pin_oe = 1'b0;
    vec_fetch = 1'b0;
    vec_addr = VEC_ADDR_HI;
    case (st_q)
      MRS_POWER, MRS_START, MRS_HOLD: begin
        reset_pin_oe = 1'b1;
      end
      MRS_VEC_HI: begin
        vec_fetch = 1'b1;
      end
      MRS_VEC_LO: begin
        vec_fetch = 1'b1;
        vec_addr = VEC_ADDR_LO;
      end
      default: begin
        reset_pin_oe = 1'b0;
      end
    endcase
  end
  assign reset_pin_o = 1'b0;
  assign reset_pin_pullup_en = 1'b1;
  assign core_rst_n = ~in_reset;
  assign periph_rst_n = ~in_reset;
  assign xtal_osc_run = 1'b1;
  assign wdog_osc_run = 1'b1;
  // Stop recovery leaves sys_q low, so of the loads below only wdog_osc_reg_load asserts
  assign ctrl_reg_load = sys_load;
  assign wdog_osc_reg_load = in_reset;
  assign wdog_ctl_rst_val = WDOG_CTL_RST;
  assign oscillator_control_reg_rst_val = OSC_CONTROL_REG_RST;
  assign clk_sel = CLKSEL_RC;
  assign clk_sel_load = sys_load;
  assign gpio_cfg_load = sys_load;
  assign gpio_dir_in = {GPIO_W{1'b1}};
  assign gpio_pullup_en = {GPIO_W{1'b0}};
  assign pc_load_val = pc_q;
  assign pc_load = pcl_q;
endmodule
`default_nettype wire
